// ---- hdl/pps_sequencer.sv ----
/*
  Power-rail sequencer with processor handshake, button events and low-power modes.
  Assumes a single 50 MHz clock, an on-clock command source, and pins that need syncing.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pps_defines.svh"

module pps_sequencer
    import pps_pkg::*;
#(
    parameter logic [15:0] GAP_TICKS = `PPS_GAP_TICKS,
    parameter logic [15:0] SETTLE_TICKS = `PPS_SETTLE_TICKS,
    parameter logic [15:0] FLASH_TICKS = `PPS_FLASH_TICKS
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic power_enable_request,
    input wire logic power_button,
    input wire logic fault_in,
    input wire logic [`PPS_NUM_RAILS-1:0] rail_good_in,
    input wire pps_cmd_type ctrl_cmd,
    input wire logic irq_ack,
    output logic [`PPS_NUM_RAILS-1:0] rail_en,
    output logic rtc_poweron_reset_n,
    output logic ldo_good_out,
    output logic rails_good_out,
    output logic wake_out,
    output logic pmic_irq_n_o,
    output logic pmic_irq_n_oe,
    output logic power_led,
    output logic [15:0] cpu_mv,
    output logic [15:0] mem_mv,
    output logic [15:0] core_mv
);

    // ------------------------------------------------------------
    // Slot decoding
    // ------------------------------------------------------------
    function automatic logic [3:0] rail_slot(input logic [2:0] rail);
        logic [3:0] s;
        s = `PPS_SLOT_NONE;
        unique case (rail)
            `PPS_RAIL_RTC: s = `PPS_SLOT_RTC;
            `PPS_RAIL_CORE: s = `PPS_SLOT_1V1;
            `PPS_RAIL_CPU: s = `PPS_SLOT_1V1;
            `PPS_RAIL_PRI33: s = `PPS_SLOT_PRI33;
            `PPS_RAIL_SW33: s = `PPS_SLOT_SW33;
            `PPS_RAIL_1V8: s = `PPS_SLOT_1V8;
            `PPS_RAIL_MEM: s = `PPS_SLOT_MEM;
            `PPS_RAIL_SEC33: s = `PPS_SLOT_NONE;
        endcase
        return s;
    endfunction : rail_slot

    function automatic logic [`PPS_NUM_RAILS-1:0] slot_mask(input logic [3:0] slot);
        logic [`PPS_NUM_RAILS-1:0] m;
        m = '0;
        for (int i = 0; i < `PPS_NUM_RAILS; i++) begin
            m[i] = (slot != `PPS_SLOT_NONE) && (rail_slot(3'(i)) == slot);
        end
        return m;
    endfunction : slot_mask

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        pps_state_type st;
        logic [3:0] slot;
        logic [15:0] cnt;
        logic pen_s1;
        logic pen_s2;
        logic btn_s1;
        logic btn_s2;
        logic btn_prev;
        logic flt_s1;
        logic flt_s2;
        logic [`PPS_NUM_RAILS-1:0] good_s1;
        logic [`PPS_NUM_RAILS-1:0] good_s2;
        pps_out_type o;
    } pps_regs_type;

    pps_regs_type state_reg;
    pps_regs_type state_next;
    logic press;
    logic all_good;
    logic sleeping;
    logic [3:0] slot_dn;

    assign press = state_reg.btn_s2 & ~state_reg.btn_prev;
    // Rails not enabled do not block the good check
    assign all_good = &(state_reg.good_s2 | ~state_reg.o.rail_en);
    assign sleeping = (state_reg.st == ST_ON)
        && ((state_reg.o.rail_en & ~`PPS_KEEP_MASK) == '0);
    assign slot_dn = state_reg.slot - 4'h1;

    always_comb begin
        state_next = state_reg;
        state_next.pen_s1 = power_enable_request;
        state_next.pen_s2 = state_reg.pen_s1;
        state_next.btn_s1 = power_button;
        state_next.btn_s2 = state_reg.btn_s1;
        state_next.btn_prev = state_reg.btn_s2;
        state_next.flt_s1 = fault_in;
        state_next.flt_s2 = state_reg.flt_s1;
        state_next.good_s1 = rail_good_in;
        state_next.good_s2 = state_reg.good_s1;

        unique case (state_reg.st)
            ST_RTC_UP: begin
                state_next.o.rail_en = `PPS_RTC_MASK;
                if (state_reg.good_s2[`PPS_RAIL_RTC]) begin
                    state_next.o.rtc_rst_n = 1'b1;
                    state_next.st = ST_WAIT_EN;
                end
            end
            ST_WAIT_EN: begin
                if (state_reg.pen_s2) begin
                    state_next.st = ST_SEQ;
                    state_next.slot = `PPS_SLOT_RTC;
                    state_next.cnt = '0;
                end
            end
            ST_SEQ: begin
                if (state_reg.cnt != '0) begin
                    state_next.cnt = state_reg.cnt - 16'h1;
                end else if (state_reg.slot == `PPS_SLOT_MEM) begin
                    state_next.st = ST_SETTLE;
                    state_next.cnt = SETTLE_TICKS;
                end else begin
                    state_next.slot = slot_dn;
                    state_next.o.rail_en = state_reg.o.rail_en | slot_mask(slot_dn);
                    // Empty slots cost one cycle, not a full gap
                    state_next.cnt = (slot_mask(slot_dn) != '0) ? GAP_TICKS : '0;
                end
            end
            ST_SETTLE: begin
                if (all_good && state_reg.o.rail_en[`PPS_RAIL_SEC33]) begin
                    state_next.st = ST_ON;
                    state_next.o.ldo_good = 1'b1;
                    state_next.o.rails_good = 1'b1;
                    state_next.o.led = 1'b1;
                end else if (state_reg.cnt == '0) begin
                    state_next.st = ST_FAULT;
                    state_next.o.led = 1'b1;
                    state_next.cnt = FLASH_TICKS;
                end else begin
                    state_next.cnt = state_reg.cnt - 16'h1;
                end
            end
            ST_ON: begin
                if (ctrl_cmd.valid && !ctrl_cmd.set_volt) begin
                    // Commands never turn the RTC rail off, so the wake path stays alive
                    if (ctrl_cmd.rail != `PPS_RAIL_RTC
                        && ctrl_cmd.rail != `PPS_RAIL_SEC33) begin
                        state_next.o.rail_en[ctrl_cmd.rail] = ctrl_cmd.on;
                    end
                end
                if (ctrl_cmd.valid && ctrl_cmd.set_volt) begin
                    if (ctrl_cmd.rail == `PPS_RAIL_CPU && ctrl_cmd.mv >= `PPS_MV_1V1) begin
                        state_next.o.cpu_mv = ctrl_cmd.mv;
                    end
                    if (ctrl_cmd.rail == `PPS_RAIL_MEM
                        && (ctrl_cmd.mv == `PPS_MV_1V5 || ctrl_cmd.mv == `PPS_MV_1V35)) begin
                        state_next.o.mem_mv = ctrl_cmd.mv;
                    end
                end
                // Processor held in reset while no rail beyond RTC and memory stays up
                state_next.o.rails_good = ~sleeping;
                state_next.o.ldo_good = ~sleeping;
                if (!sleeping) begin
                    state_next.o.wake = 1'b0;
                end
                if (irq_ack) begin
                    state_next.o.irq_oe = 1'b0;
                end
                if (press && sleeping) begin
                    state_next.o.wake = 1'b1;
                end
                if (press && !sleeping) begin
                    state_next.o.irq_oe = 1'b1;
                end
            end
            ST_FAULT: begin
                // Latched until reset: a shut-down supply is not retried
                state_next.o.rail_en = '0;
                state_next.o.rtc_rst_n = 1'b0;
                state_next.o.ldo_good = 1'b0;
                state_next.o.rails_good = 1'b0;
                state_next.o.wake = 1'b0;
                state_next.o.irq_oe = 1'b0;
                if (state_reg.cnt != '0) begin
                    state_next.cnt = state_reg.cnt - 16'h1;
                end else begin
                    state_next.o.led = 1'b0;
                end
            end
        endcase

        if (state_reg.flt_s2 && state_reg.st != ST_FAULT
            && state_reg.st != ST_RTC_UP && state_reg.st != ST_WAIT_EN) begin
            state_next.st = ST_FAULT;
            state_next.o.rail_en = '0;
            // Goods drop with the rails, not one edge later
            state_next.o.ldo_good = 1'b0;
            state_next.o.rails_good = 1'b0;
            // Only an interrupted power-up flashes the LED
            state_next.o.led = (state_reg.st != ST_ON);
            state_next.cnt = (state_reg.st != ST_ON) ? FLASH_TICKS : '0;
        end

        // Secondary 3.3V tracks the primary one tick later
        if (state_next.st != ST_FAULT) begin
            state_next.o.rail_en[`PPS_RAIL_SEC33] = state_reg.o.rail_en[`PPS_RAIL_PRI33];
        end
        state_next.o.core_mv = `PPS_MV_1V1;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg <= '0;
            state_reg.st <= ST_RTC_UP;
            state_reg.o.cpu_mv <= `PPS_MV_1V1;
            state_reg.o.mem_mv <= `PPS_MV_1V5;
            state_reg.o.core_mv <= `PPS_MV_1V1;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rail_en = state_reg.o.rail_en;
    assign rtc_poweron_reset_n = state_reg.o.rtc_rst_n;
    assign ldo_good_out = state_reg.o.ldo_good;
    assign rails_good_out = state_reg.o.rails_good;
    assign wake_out = state_reg.o.wake;
    assign pmic_irq_n_o = 1'b0;
    assign pmic_irq_n_oe = state_reg.o.irq_oe;
    assign power_led = state_reg.o.led;
    assign cpu_mv = state_reg.o.cpu_mv;
    assign mem_mv = state_reg.o.mem_mv;
    assign core_mv = state_reg.o.core_mv;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    property p_rtc_only_first;
        (state_reg.st == ST_WAIT_EN) |-> (rail_en == `PPS_RTC_MASK);
    endproperty
    a_rtc_only_first: assert property (p_rtc_only_first)
        else $error("rails other than RTC enabled before request");

    property p_rtc_reset_after_good;
        $rose(rtc_poweron_reset_n) |-> $past(state_reg.good_s2[0]) && rail_en[0];
    endproperty
    a_rtc_reset_after_good: assert property (p_rtc_reset_after_good)
        else $error("RTC reset released before RTC rail good");

    property p_wait_request;
        (state_reg.st == ST_WAIT_EN && !state_reg.pen_s2) |=> (state_reg.st == ST_WAIT_EN);
    endproperty
    a_wait_request: assert property (p_wait_request)
        else $error("sequence started without power enable request");

    property p_slot_down;
        (state_reg.st == ST_SEQ && state_reg.cnt == '0 && state_reg.slot > 4'h1 && !state_reg.flt_s2)
            |=> (state_reg.slot == $past(state_reg.slot) - 4'h1);
    endproperty
    a_slot_down: assert property (p_slot_down)
        else $error("strobe slot did not step down by one");

    property p_mem_slot_one;
        $rose(rail_en[6]) && state_reg.st == ST_SEQ |-> (state_reg.slot == 4'h1);
    endproperty
    a_mem_slot_one: assert property (p_mem_slot_one)
        else $error("memory rail enabled outside slot 1");

    property p_secondary_follows;
        $rose(rail_en[7]) |-> $past(rail_en[3]) && rail_en[3];
    endproperty
    a_secondary_follows: assert property (p_secondary_follows)
        else $error("secondary 3.3V enabled without primary");

    property p_good_when_up;
        $rose(rails_good_out) && $past(state_reg.st) == ST_SETTLE |-> $past(all_good);
    endproperty
    a_good_when_up: assert property (p_good_when_up)
        else $error("rails good raised before all rails up");

    property p_press_wakes;
        (press && sleeping && !state_reg.flt_s2) |=> wake_out;
    endproperty
    a_press_wakes: assert property (p_press_wakes)
        else $error("button in sleep did not raise wake");

    property p_press_irq;
        (press && state_reg.st == ST_ON && !sleeping && !state_reg.flt_s2)
            |=> pmic_irq_n_oe ##1 (pmic_irq_n_oe || $past(irq_ack) || state_reg.st == ST_FAULT);
    endproperty
    a_press_irq: assert property (p_press_irq)
        else $error("button while running did not raise interrupt");

    property p_core_fixed;
        ##1 (core_mv == `PPS_MV_1V1);
    endproperty
    a_core_fixed: assert property (p_core_fixed)
        else $error("core rail voltage changed");

    property p_mem_legal;
        (mem_mv == `PPS_MV_1V5) || (mem_mv == `PPS_MV_1V35);
    endproperty
    a_mem_legal: assert property (p_mem_legal)
        else $error("memory rail voltage illegal");

    property p_skip_empty;
        (state_reg.st == ST_SEQ && state_reg.cnt == '0 && state_reg.slot > 4'h1
            && slot_mask(slot_dn) == '0 && !state_reg.flt_s2) |=> (state_reg.cnt == '0);
    endproperty
    a_skip_empty: assert property (p_skip_empty)
        else $error("empty slot was given a wait");

    property p_ldo_tracks_rails;
        ldo_good_out == rails_good_out;
    endproperty
    a_ldo_tracks_rails: assert property (p_ldo_tracks_rails)
        else $error("LDO good and rails good disagree");

    property p_rtc_kept;
        (state_reg.st == ST_ON) |-> rail_en[`PPS_RAIL_RTC];
    endproperty
    a_rtc_kept: assert property (p_rtc_kept)
        else $error("RTC rail off while running or asleep");

endmodule : pps_sequencer

`default_nettype wire

// ---- hdl/pps_defines.svh ----
/*
  Constants of the rail sequencer: rail indices, strobe slots, voltages, tick counts.
  Assumes inclusion by bare name from the package and the sequencer module.
*/
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH

`define PPS_NUM_RAILS 8
`define PPS_RAIL_RTC 3'h0
`define PPS_RAIL_CORE 3'h1
`define PPS_RAIL_CPU 3'h2
`define PPS_RAIL_PRI33 3'h3
`define PPS_RAIL_SW33 3'h4
`define PPS_RAIL_1V8 3'h5
`define PPS_RAIL_MEM 3'h6
`define PPS_RAIL_SEC33 3'h7

`define PPS_SLOT_RTC 4'hf
`define PPS_SLOT_1V1 4'h5
`define PPS_SLOT_PRI33 4'h4
`define PPS_SLOT_SW33 4'h3
`define PPS_SLOT_1V8 4'h2
`define PPS_SLOT_MEM 4'h1
`define PPS_SLOT_NONE 4'h0

`define PPS_MV_1V1 16'h044c
`define PPS_MV_1V5 16'h05dc
`define PPS_MV_1V35 16'h0546

`define PPS_KEEP_MASK 8'h41
`define PPS_RTC_MASK 8'h01

`define PPS_GAP_TICKS 16'h0010
`define PPS_SETTLE_TICKS 16'h0100
`define PPS_FLASH_TICKS 16'h0800

`endif

// ---- hdl/pps_pkg.sv ----
/*
  Types of the rail sequencer: state enumeration, command and output carriers.
  Assumes pps_defines.svh on the include path.
*/
`include "pps_defines.svh"

package pps_pkg;

    typedef enum logic [2:0] {
        ST_RTC_UP, ST_WAIT_EN, ST_SEQ, ST_SETTLE, ST_ON, ST_FAULT
    } pps_state_type;

    typedef struct packed {
        logic valid;
        logic set_volt;
        logic [2:0] rail;
        logic on;
        logic [15:0] mv;
    } pps_cmd_type;

    typedef struct packed {
        logic [`PPS_NUM_RAILS-1:0] rail_en;
        logic rtc_rst_n;
        logic ldo_good;
        logic rails_good;
        logic wake;
        logic irq_oe;
        logic led;
        logic [15:0] cpu_mv;
        logic [15:0] mem_mv;
        logic [15:0] core_mv;
    } pps_out_type;

endpackage : pps_pkg

// ---- testbench/pps_host_model.sv ----
/*
  Host processor model: power-enable handshake and rail power-good feedback.
  Assumes the sequencer on the same clock; drives its pins 1 ns after the edge.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pps_defines.svh"

module pps_host_model #(
    parameter int PEN_DELAY = 5,
    parameter int RTC_LAG = 10
) (
    input wire logic ref_clk,
    input wire logic rtc_poweron_reset_n,
    input wire logic [`PPS_NUM_RAILS-1:0] rail_en,
    output logic power_enable_request,
    output logic [`PPS_NUM_RAILS-1:0] rail_good_in
);
    int rtc_cnt = 0;
    int pen_cnt = 0;

    // ----
    // Slow RTC rail, prompt others
    // ----
    always @(posedge ref_clk) begin
        rtc_cnt = rail_en[0] ? rtc_cnt + 1 : 0;
        pen_cnt = rtc_poweron_reset_n ? pen_cnt + 1 : 0;
        #1;
        rail_good_in <= {rail_en[`PPS_NUM_RAILS-1:1], 1'(rtc_cnt > RTC_LAG)};
        // Request only once the RTC domain has been out of reset a while
        power_enable_request <= (pen_cnt > PEN_DELAY);
    end
endmodule : pps_host_model
`default_nettype wire

// ---- testbench/testbench.sv ----
/*
  Self-checking bench of the rail sequencer with a host model on the far side.
  Assumes small tick parameters so the whole run stays short.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pps_defines.svh"

module testbench
    import pps_pkg::*;
;
    typedef struct packed {
        logic [7:0] val;
        logic [7:0] gap;
    } pps_exp_type;
    localparam logic [7:0] G1 = 8'h03;
    localparam logic [2:0] SEQ_RAIL [5] = '{`PPS_RAIL_PRI33, `PPS_RAIL_SEC33, `PPS_RAIL_SW33,
        `PPS_RAIL_1V8, `PPS_RAIL_MEM};
    localparam logic [7:0] SEQ_GAP [5] = '{G1, 8'h01, 8'h02, G1, G1};

    logic ref_clk, srst, power_enable_request, power_button, fault_in, irq_ack;
    logic [7:0] rail_good_in, rail_en;
    pps_cmd_type ctrl_cmd;
    logic rtc_poweron_reset_n, ldo_good_out, rails_good_out, wake_out;
    logic pmic_irq_n_o, pmic_irq_n_oe, power_led;
    logic [15:0] cpu_mv, mem_mv, core_mv;
    wire logic irq_line = pmic_irq_n_oe ? pmic_irq_n_o : 1'b1;
    pps_exp_type exp_q[$];
    int n_errors = 0;
    int compares = 0;

    pps_sequencer #(.GAP_TICKS(16'h0002), .SETTLE_TICKS(16'h0008), .FLASH_TICKS(16'h0004))
    i_pps_sequencer (.ref_clk(ref_clk), .srst(srst), .power_enable_request(power_enable_request),
        .power_button(power_button), .fault_in(fault_in), .rail_good_in(rail_good_in),
        .ctrl_cmd(ctrl_cmd), .irq_ack(irq_ack), .rail_en(rail_en),
        .rtc_poweron_reset_n(rtc_poweron_reset_n), .ldo_good_out(ldo_good_out),
        .rails_good_out(rails_good_out), .wake_out(wake_out), .pmic_irq_n_o(pmic_irq_n_o),
        .pmic_irq_n_oe(pmic_irq_n_oe), .power_led(power_led), .cpu_mv(cpu_mv),
        .mem_mv(mem_mv), .core_mv(core_mv));

    pps_host_model i_pps_host_model (.ref_clk(ref_clk),
        .rtc_poweron_reset_n(rtc_poweron_reset_n), .rail_en(rail_en),
        .power_enable_request(power_enable_request), .rail_good_in(rail_good_in));

    // ----
    // Helpers
    // ----
    task automatic conclude();
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic expect_en(input logic [7:0] v, input logic [7:0] g);
        exp_q.push_back('{val: v, gap: g});
    endtask : expect_en

    task automatic cmd(input logic sv, input logic [2:0] r, input logic on, input logic [15:0] mv);
        ctrl_cmd = '{valid: 1'b1, set_volt: sv, rail: r, on: on, mv: mv};
        tick(1);
        ctrl_cmd.valid = 1'b0;
        tick(3);
    endtask : cmd

    task automatic vcmd(input logic [2:0] r, input logic [15:0] mv, input logic [15:0] c,
        input logic [15:0] m);
        cmd(1'b1, r, 1'b0, mv);
        check(cpu_mv, c);
        check(mem_mv, m);
        check(core_mv, `PPS_MV_1V1);
    endtask : vcmd

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        conclude();
    end

    // ----
    // Monitor: every enable change outside reset takes the oldest note, gap in cycles if given
    // ----
    initial begin
        pps_exp_type e;
        logic [7:0] last_en;
        int since;
        since = 0;
        forever begin
            @(posedge ref_clk);
            #2;
            since++;
            if (srst) begin
                last_en = rail_en;
                since = 0;
            end else if (rail_en !== last_en) begin
                e = '{val: ~rail_en, gap: 8'h00};
                if (exp_q.size() > 0) e = exp_q.pop_front();
                check(rail_en, e.val);
                if (e.gap != 8'h00) check(16'(since), e.gap);
                last_en = rail_en;
                since = 0;
            end
        end
    end

    // ----
    // Scenarios
    // ----
    initial begin
        int i;
        int seed;
        logic [7:0] en;
        logic [2:0] r;
        logic [15:0] mv;
        logic self_refresh;
        srst = 1'b1;
        power_button = 1'b0;
        fault_in = 1'b0;
        irq_ack = 1'b0;
        ctrl_cmd = '0;
        self_refresh = 1'b0;
        seed = $urandom(95830);
        tick(6);
        check(rail_en, 8'h00);
        check(cpu_mv, `PPS_MV_1V1);
        check(mem_mv, `PPS_MV_1V5);
        expect_en(8'h01, 8'h00);
        srst = 1'b0;
        for (i = 0; i < 60 && rtc_poweron_reset_n !== 1'b1; i++) tick(1);
        check(rtc_poweron_reset_n, 1'b1);
        check(rail_good_in[0], 1'b1);
        check(power_enable_request, 1'b0);
        en = 8'h07;
        expect_en(en, 8'h00);
        for (i = 0; i < 5; i++) begin
            en |= 8'h01 << SEQ_RAIL[i];
            expect_en(en, SEQ_GAP[i]);
        end
        for (i = 0; i < 200 && rails_good_out !== 1'b1; i++) tick(1);
        check(rails_good_out, 1'b1);
        check(16'(exp_q.size()), 16'h0000);
        check(ldo_good_out, 1'b1);
        check(power_led, 1'b1);
        vcmd(`PPS_RAIL_CPU, 16'h04b0, 16'h04b0, `PPS_MV_1V5);
        vcmd(`PPS_RAIL_CPU, 16'h03e8, 16'h04b0, `PPS_MV_1V5);
        vcmd(`PPS_RAIL_MEM, `PPS_MV_1V35, 16'h04b0, `PPS_MV_1V35);
        vcmd(`PPS_RAIL_MEM, 16'h0578, 16'h04b0, `PPS_MV_1V35);
        vcmd(`PPS_RAIL_CORE, 16'h04b0, 16'h04b0, `PPS_MV_1V35);
        mv = 16'(`PPS_MV_1V1 + $urandom_range(400));
        vcmd(`PPS_RAIL_CPU, mv, mv, `PPS_MV_1V35);
        r = 3'($urandom_range(5) + 1);
        if (r == `PPS_RAIL_PRI33) r = `PPS_RAIL_SW33;
        expect_en(8'hff & ~(8'h01 << r), 8'h00);
        cmd(1'b0, r, 1'b0, 16'h0000);
        expect_en(8'hff, 8'h00);
        cmd(1'b0, r, 1'b1, 16'h0000);
        cmd(1'b0, `PPS_RAIL_RTC, 1'b0, 16'h0000);
        power_button = 1'b1;
        tick(6);
        power_button = 1'b0;
        check(irq_line, 1'b0);
        check(wake_out, 1'b0);
        irq_ack = 1'b1;
        tick(1);
        irq_ack = 1'b0;
        tick(2);
        check(pmic_irq_n_oe, 1'b0);
        check(irq_line, 1'b1);
        self_refresh = 1'b1;
        for (i = 1; i < 6; i++) begin
            en &= ~(8'h01 << i);
            expect_en(en, 8'h00);
            if (i == `PPS_RAIL_PRI33) begin
                en &= ~(8'h01 << `PPS_RAIL_SEC33);
                expect_en(en, 8'h01);
            end
            cmd(1'b0, 3'(i), 1'b0, 16'h0000);
        end
        check(rail_en, `PPS_KEEP_MASK);
        check(rails_good_out, 1'b0);
        check(ldo_good_out, 1'b0);
        check(rail_en[`PPS_RAIL_MEM], self_refresh);
        power_button = 1'b1;
        tick(6);
        power_button = 1'b0;
        check(wake_out, 1'b1);
        expect_en(`PPS_RTC_MASK, 8'h00);
        cmd(1'b0, `PPS_RAIL_MEM, 1'b0, 16'h0000);
        check(wake_out, 1'b1);
        expect_en(`PPS_RTC_MASK | (8'h01 << `PPS_RAIL_SW33), 8'h00);
        cmd(1'b0, `PPS_RAIL_SW33, 1'b1, 16'h0000);
        check(wake_out, 1'b0);
        check(rails_good_out, 1'b1);
        // Second power-up broken by a fault before any rail of the run is on
        srst = 1'b1;
        tick(6);
        expect_en(8'h01, 8'h00);
        srst = 1'b0;
        for (i = 0; i < 60 && power_enable_request !== 1'b1; i++) tick(1);
        check(power_enable_request, 1'b1);
        tick(3);
        fault_in = 1'b1;
        expect_en(8'h00, 8'h00);
        for (i = 0; i < 20 && power_led !== 1'b1; i++) tick(1);
        check(power_led, 1'b1);
        for (i = 0; i < 20 && power_led === 1'b1; i++) tick(1);
        check(16'(i), 16'h0005);
        tick(3);
        check(power_led, 1'b0);
        check(16'(exp_q.size()), 16'h0000);
        conclude();
    end
endmodule : testbench
`default_nettype wire
